//--- hdl/flash_lock_cmd.sv
// Lock-bit, software-reset and counter command decoder of the flash
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Lock read: opcode 3Dh then 24-bit address, shifted in on rising edges.
// - After the address the lock byte shifts out on falling edges, MSB first.
// - Lock byte LSB one means locked, zero means unlocked.
// - Lock bits protect only when scheme select is one; else range protection.
// - All lock bits are one after power-up and after any reset.
// - Global lock 7Eh alone sets every lock bit when write enable latch set.
// - Global unlock 98h alone clears every lock bit when latch set.
// - Software reset is reset-enable 66h then reset 99h, separate frames.
// - Any other command after reset-enable drops the armed state.
// - Accepted reset clears volatile status, latch, suspend, read and wrap.
// - After reset all commands are ignored for 30 microseconds.
// - Root key write checks 64-byte payload, address range, uninit flag FFh.
// - Root key write checks truncated signature against computed HMAC.
// - A passing counter command executes and posts success status.
// - Root key init flag is cleared to zero as the final step.
// - All-ones key is temporary: flag kept, uninitialised counter zeroed.
// - An initialised counter keeps its value on any root key write.
// - After a real key write, later root key writes are rejected.
// - HMAC key update checks 40 bytes, range, init counter, signature.
// - Busy stays set for twice the polling delay during key update.
// - A failing counter command is not executed; error status posted.
// - Reserved counter command types post error with status bit 2.
module flash_lock_cmd
   import flash_lock_pkg::*;
#(
   parameter int POLL_CYC = POLL_CYC_DEF
) (
   // Clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  resetn_in,
   // Serial interface, sampled on clk_in
   input  wire logic                  cs_n_in,
   input  wire logic                  sclk_in,
   input  wire logic                  serial_in,
   output logic                       serial_out_q_out,
   output logic                       serial_oe_out,
   // Protection configuration and query
   input  wire logic                  write_enable_latch_in,
   input  wire logic                  lock_scheme_select_in,
   input  wire logic                  range_protected_in,
   input  wire logic [23:0]           prot_addr_in,
   output logic                       prot_out,
   // Side effects on the rest of the device
   output logic                       sw_reset_out,
   output logic                       wel_clear_out,
   output logic                       busy_out,
   // Counter command status and state
   output logic [7:0]                 ctr_status_out,
   output logic [NUM_CTRS-1:0]        counter_init_flag_out,
   output logic [NUM_CTRS-1:0]        hmac_key_valid_out,
   output logic                       counter_zero_out,
   output logic [1:0]                 counter_idx_out,
   // Signature engine
   output logic [7:0]                 rx_byte_out,
   output logic                       rx_valid_out,
   output logic                       hmac_start_out,
   output logic [7:0]                 hmac_type_out,
   input  wire logic                  hmac_done_in,
   input  wire logic                  hmac_match_in
);

   ctl_state_t            state_q;
   logic                  sclk_q;
   logic                  cs_q;
   logic [7:0]            shift_q;
   logic [2:0]            bit_q;
   logic [6:0]            byte_q;
   logic [7:0]            opcode_q;
   logic [7:0]            type_q;
   logic [7:0]            ctr_addr_q;
   logic [23:0]           addr_q;
   logic                  key_ones_q;
   logic                  armed_q;
   logic [LOCK_BITS-1:0]  lock_q;
   logic [7:0]            root_flag_q [NUM_CTRS];
   logic [NUM_CTRS-1:0]   ctr_init_q;
   logic [NUM_CTRS-1:0]   hkey_q;
   logic [15:0]           tmr_q;
   logic [7:0]            out_byte_q;

   logic                  rise;
   logic                  fall;
   logic                  frame_end;
   logic                  byte_done;
   logic [7:0]            byte_val;
   logic                  live;
   logic [1:0]            cidx;
   logic                  in_range;
   logic                  rst_go;

   // Synchronous pins: edges are found against the previous sample
   assign rise      = sclk_in & ~sclk_q & ~cs_n_in;
   assign fall      = ~sclk_in & sclk_q & ~cs_n_in;
   assign frame_end = cs_n_in & ~cs_q;
   assign byte_val  = {shift_q[6:0], serial_in};
   assign byte_done = rise && bit_q == BIT_LAST;
   // Frames are ignored during reset recovery and counter execution
   assign live      = state_q == S_IDLE;
   assign cidx      = ctr_addr_q[1:0];
   assign in_range  = ctr_addr_q < 8'(NUM_CTRS);
   assign rst_go    = live && frame_end && armed_q && byte_q == LEN_OPCODE
                      && bit_q == 3'h0 && opcode_q == OP_RST_DEVICE;

   // Edge history
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
      end else begin
         sclk_q <= sclk_in;
         cs_q   <= cs_n_in;
      end
   end

   // Input shifter and byte counter, restarted by chip select
   always_ff @(posedge clk_in) begin
      if (!resetn_in || cs_n_in) begin
         shift_q <= 8'h00;
         bit_q   <= 3'h0;
         byte_q  <= 7'h00;
      end else if (rise) begin
         shift_q <= byte_val;
         bit_q   <= bit_q + 3'h1;
         if (byte_done && byte_q != BY_MAX)
            byte_q <= byte_q + 7'h01;
      end
   end

   // Capture opcode, address and counter header bytes
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         opcode_q   <= 8'h00;
         type_q     <= 8'h00;
         ctr_addr_q <= 8'h00;
         addr_q     <= 24'h000000;
         key_ones_q <= 1'b1;
      end else if (byte_done && live) begin
         if (byte_q == 7'h00) begin
            opcode_q   <= byte_val;
            key_ones_q <= 1'b1;
         end
         if (byte_q >= BY_TYPE && byte_q <= BY_ADDR_LAST)
            addr_q <= {addr_q[15:0], byte_val};
         if (byte_q == BY_TYPE)
            type_q <= byte_val;
         if (byte_q == BY_CTR_ADDR)
            ctr_addr_q <= byte_val;
         // Track an all-ones root key as it streams past
         if (byte_q >= BY_KEY_FIRST && byte_q <= BY_KEY_LAST
             && byte_val != 8'hff)
            key_ones_q <= 1'b0;
      end
   end

   // Counter frame bytes are forwarded to the signature engine
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         rx_byte_out  <= 8'h00;
         rx_valid_out <= 1'b0;
      end else begin
         rx_valid_out <= byte_done && live && opcode_q == OP_COUNTER
                         && byte_q != 7'h00;
         if (byte_done)
            rx_byte_out <= byte_val;
      end
   end

   // Lock read answer: LSB carries the lock bit, MSB leaves first
   always_ff @(posedge clk_in) begin
      if (!resetn_in || cs_n_in) begin
         serial_out_q_out <= 1'b0;
         serial_oe_out    <= 1'b0;
         out_byte_q       <= 8'h00;
      end else if (fall && live && opcode_q == OP_READ_LOCK
                   && byte_q > BY_ADDR_LAST) begin
         serial_oe_out <= 1'b1;
         if (bit_q == 3'h0) begin
            // Only the region index bits pick the lock bit
            serial_out_q_out <= 1'b0;
            out_byte_q <= {7'h00,
               lock_q[addr_q[LOCK_IDX_LO +: LOCK_IDX_W]]};
         end else begin
            serial_out_q_out <= out_byte_q[3'h7 - bit_q];
         end
      end
   end

   // Volatile lock bits: all locked at power-up and on software reset
   always_ff @(posedge clk_in) begin
      if (!resetn_in || rst_go) begin
         lock_q <= '1;
      end else if (live && frame_end && write_enable_latch_in
                   && byte_q == LEN_OPCODE && bit_q == 3'h0) begin
         if (opcode_q == OP_GLOBAL_LOCK)
            lock_q <= '1;
         else if (opcode_q == OP_GLOBAL_UNLK)
            lock_q <= '0;
      end
   end

   // Protection answer follows the selected scheme
   always_ff @(posedge clk_in) begin
      if (!resetn_in)
         prot_out <= 1'b1;
      else if (lock_scheme_select_in)
         prot_out <= lock_q[prot_addr_in[LOCK_IDX_LO +: LOCK_IDX_W]];
      else
         prot_out <= range_protected_in;
   end

   // Reset-enable arming; any other completed frame disarms it
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         armed_q <= 1'b0;
      end else if (live && frame_end && byte_q != 7'h00) begin
         armed_q <= opcode_q == OP_RST_ENABLE && byte_q == LEN_OPCODE;
      end
   end

   // Reset pulse lets the rest of the device drop its volatile state
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sw_reset_out  <= 1'b0;
         wel_clear_out <= 1'b0;
      end else begin
         sw_reset_out  <= rst_go;
         wel_clear_out <= rst_go;
      end
   end

   // Control sequencer: recovery, signature wait and final commit
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_q        <= S_IDLE;
         tmr_q          <= 16'h0000;
         hmac_start_out <= 1'b0;
         hmac_type_out  <= 8'h00;
         ctr_status_out <= ST_IDLE;
      end else begin
         hmac_start_out <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (rst_go) begin
                  state_q <= S_RECOVER;
                  tmr_q   <= 16'(RST_CYC);
               end else if (frame_end && opcode_q == OP_COUNTER
                            && byte_q > BY_TYPE) begin
                  if (type_q >= CT_FIRST_RSVD)
                     ctr_status_out <= ST_ERR_RSVD;
                  else if (type_q == CT_ROOT_KEY
                           && (byte_q != LEN_ROOT_KEY || bit_q != 3'h0
                               || !in_range))
                     ctr_status_out <= ST_ERR_PARAM;
                  else if (type_q == CT_ROOT_KEY
                           && root_flag_q[cidx] != ROOT_UNINIT)
                     ctr_status_out <= ST_ERR_STATE;
                  else if (type_q == CT_HMAC_KEY
                           && (byte_q != LEN_HMAC_KEY || bit_q != 3'h0
                               || !in_range))
                     ctr_status_out <= ST_ERR_PARAM;
                  else if (type_q == CT_HMAC_KEY && !ctr_init_q[cidx])
                     ctr_status_out <= ST_ERR_STATE;
                  else if (type_q == CT_ROOT_KEY
                           || type_q == CT_HMAC_KEY) begin
                     // Two signature passes hold busy twice as long
                     state_q        <= S_HMAC_WAIT;
                     hmac_start_out <= 1'b1;
                     hmac_type_out  <= type_q;
                     tmr_q <= (type_q == CT_HMAC_KEY)
                              ? 16'(2 * POLL_CYC) : 16'(POLL_CYC);
                  end else begin
                     ctr_status_out <= ST_ERR_RSVD;
                  end
               end
            end
            S_RECOVER: begin
               if (tmr_q <= TMR_ONE)
                  state_q <= S_IDLE;
               tmr_q <= tmr_q - TMR_ONE;
            end
            S_HMAC_WAIT: begin
               if (tmr_q > TMR_ONE)
                  tmr_q <= tmr_q - TMR_ONE;
               else if (hmac_done_in) begin
                  if (!hmac_match_in) begin
                     state_q        <= S_IDLE;
                     ctr_status_out <= ST_ERR_SIG;
                  end else
                     state_q <= S_COMMIT;
               end
            end
            S_COMMIT: begin
               state_q        <= S_IDLE;
               ctr_status_out <= ST_SUCCESS;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Busy covers recovery and counter execution
   always_ff @(posedge clk_in) begin
      if (!resetn_in)
         busy_out <= 1'b0;
      else
         busy_out <= state_q != S_IDLE || rst_go;
   end

   // Counter state updates happen one step before the root key flag
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ctr_init_q       <= '0;
         counter_zero_out <= 1'b0;
         counter_idx_out  <= 2'h0;
      end else begin
         counter_zero_out <= 1'b0;
         if (state_q == S_HMAC_WAIT && tmr_q <= TMR_ONE && hmac_done_in
             && hmac_match_in && type_q == CT_ROOT_KEY
             && !ctr_init_q[cidx]) begin
            // An initialised counter is left alone
            ctr_init_q[cidx] <= 1'b1;
            counter_zero_out <= 1'b1;
            counter_idx_out  <= cidx;
         end
      end
   end

   // Root key flags: cleared last, and only for a real key
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < NUM_CTRS; i++)
            root_flag_q[i] <= ROOT_UNINIT;
      end else if (state_q == S_COMMIT && type_q == CT_ROOT_KEY
                   && !key_ones_q) begin
         root_flag_q[cidx] <= ROOT_INIT;
      end
   end

   // Volatile HMAC key registers, lost on software reset
   always_ff @(posedge clk_in) begin
      if (!resetn_in || rst_go)
         hkey_q <= '0;
      else if (state_q == S_COMMIT && type_q == CT_HMAC_KEY)
         hkey_q[cidx] <= 1'b1;
   end

   // Flag mirrors for the outside
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         counter_init_flag_out <= '0;
         hmac_key_valid_out    <= '0;
      end else begin
         counter_init_flag_out <= ctr_init_q;
         hmac_key_valid_out    <= hkey_q;
      end
   end

endmodule

`default_nettype wire

//--- hdl/flash_lock_pkg.sv
// Constants shared by the lock, reset and counter command decoder
package flash_lock_pkg;
   // Opcodes
   localparam logic [7:0] OP_READ_LOCK   = 8'h3d;
   localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
   localparam logic [7:0] OP_GLOBAL_UNLK = 8'h98;
   localparam logic [7:0] OP_RST_ENABLE  = 8'h66;
   localparam logic [7:0] OP_RST_DEVICE  = 8'h99;
   localparam logic [7:0] OP_COUNTER     = 8'h9b;
   // Counter command types
   localparam logic [7:0] CT_ROOT_KEY    = 8'h00;
   localparam logic [7:0] CT_HMAC_KEY    = 8'h01;
   localparam logic [7:0] CT_FIRST_RSVD  = 8'h04;
   // Frame byte positions (byte 0 is the opcode)
   localparam logic [6:0] BY_TYPE        = 7'h01;
   localparam logic [6:0] BY_CTR_ADDR    = 7'h02;
   localparam logic [6:0] BY_ADDR_LAST   = 7'h03;
   localparam logic [6:0] BY_KEY_FIRST   = 7'h04;
   localparam logic [6:0] BY_KEY_LAST    = 7'h23;
   localparam logic [6:0] BY_MAX         = 7'h7f;
   // Frame lengths: opcode plus operand payload
   localparam logic [6:0] LEN_ROOT_KEY   = 7'h41;
   localparam logic [6:0] LEN_HMAC_KEY   = 7'h29;
   localparam logic [6:0] LEN_OPCODE     = 7'h01;
   // Lock map and counters
   localparam int         LOCK_BITS      = 16;
   localparam int         LOCK_IDX_LO    = 20;
   localparam int         LOCK_IDX_W     = 4;
   localparam int         NUM_CTRS       = 4;
   localparam logic [7:0] ROOT_UNINIT    = 8'hff;
   localparam logic [7:0] ROOT_INIT      = 8'h00;
   // Counter status codes
   localparam logic [7:0] ST_IDLE        = 8'h00;
   localparam logic [7:0] ST_SUCCESS     = 8'h80;
   localparam logic [7:0] ST_ERR_RSVD    = 8'h04;
   localparam logic [7:0] ST_ERR_SIG     = 8'h02;
   localparam logic [7:0] ST_ERR_PARAM   = 8'h08;
   localparam logic [7:0] ST_ERR_STATE   = 8'h10;
   // Timing
   localparam int         CLK_MHZ        = 10;
   localparam int         T_RST_US       = 30;
   localparam int         RST_CYC        = T_RST_US * CLK_MHZ;
   localparam int         POLL_CYC_DEF   = 200;
   localparam logic [2:0] BIT_LAST       = 3'h7;
   localparam logic [15:0] TMR_ONE       = 16'h0001;
   typedef enum logic [1:0] {S_IDLE, S_RECOVER, S_HMAC_WAIT, S_COMMIT}
      ctl_state_t;
endpackage

//--- tb/flash_lock_cmd_asserts.sv
// Port-level assertions for the lock, reset and counter command decoder
`timescale 1ns/1ps
`default_nettype none
module flash_lock_cmd_asserts
   import flash_lock_pkg::*;
#(
   parameter int POLL_CYC = POLL_CYC_DEF
) (
   // Clock, reset and host side inputs
   input wire logic       clk_in,
   input wire logic       resetn_in,
   input wire logic       cs_n_in,
   input wire logic       lock_scheme_select_in,
   input wire logic       range_protected_in,
   // Design outputs
   input wire logic       serial_oe_out,
   input wire logic       prot_out,
   input wire logic       sw_reset_out,
   input wire logic       wel_clear_out,
   input wire logic       busy_out,
   input wire logic [7:0] ctr_status_out,
   input wire logic       counter_zero_out,
   input wire logic       hmac_start_out,
   input wire logic [7:0] hmac_type_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   int unsigned busy_cnt_q;

   // Length of the current busy stretch; a repetition cannot hold the count
   always_ff @(posedge clk_in) begin
      if (!resetn_in || !busy_out)
         busy_cnt_q <= 0;
      else
         busy_cnt_q <= busy_cnt_q + 1;
   end

   AST_RESET_LOCKED: assert property ($rose(resetn_in) |-> prot_out)
      else $error("array not protected at reset release");
   AST_PROT_RANGE: assert property (
      !lock_scheme_select_in |=> prot_out == $past(range_protected_in))
      else $error("range protection not followed");
   AST_WEL_PAIR: assert property (
      sw_reset_out |-> wel_clear_out ##1 !sw_reset_out && !wel_clear_out)
      else $error("reset pulse without latch clear");
   AST_RECOVER_BUSY: assert property (sw_reset_out |=> ##1 busy_out [*8])
      else $error("busy dropped during reset recovery");
   AST_START_BUSY: assert property (
      hmac_start_out |-> cs_n_in ##2 busy_out [*4])
      else $error("signature check started without busy");
   AST_SUCCESS_BUSY: assert property (
      $changed(ctr_status_out) && ctr_status_out == ST_SUCCESS
      |-> $past(busy_out))
      else $error("success posted without execution");
   AST_ZERO_PULSE: assert property (
      counter_zero_out |-> busy_out ##1 !counter_zero_out)
      else $error("counter zeroing outside a command");
   AST_OE_FRAME: assert property (serial_oe_out |-> !$past(cs_n_in, 2))
      else $error("output driven outside a frame");
   AST_KEY_BUSY: assert property (
      $fell(busy_out) && hmac_type_out == CT_HMAC_KEY
      && ctr_status_out == ST_SUCCESS |-> busy_cnt_q >= 2 * POLL_CYC)
      else $error("key update busy too short");
endmodule

bind flash_lock_cmd flash_lock_cmd_asserts #(.POLL_CYC(POLL_CYC)) i_chk (
   .clk_in(clk_in), .resetn_in(resetn_in), .cs_n_in(cs_n_in),
   .lock_scheme_select_in(lock_scheme_select_in),
   .range_protected_in(range_protected_in), .serial_oe_out(serial_oe_out),
   .prot_out(prot_out), .sw_reset_out(sw_reset_out),
   .wel_clear_out(wel_clear_out), .busy_out(busy_out),
   .ctr_status_out(ctr_status_out), .counter_zero_out(counter_zero_out),
   .hmac_start_out(hmac_start_out), .hmac_type_out(hmac_type_out));
`default_nettype wire

//--- tb/spi_host_model.sv
// Behavioural flash controller that frames commands on the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Clock and device state
   input  wire logic clk_in,
   input  wire logic busy_in,
   input  wire logic miso_in,
   // Serial link towards the device
   output logic      cs_n_out,
   output logic      sclk_out,
   output logic      mosi_out
);
   logic [7:0] buf_q [0:79];

   // Link idles deselected with the clock parked low
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      mosi_out = 1'b0;
   end

   // Everything moves just after a system clock edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // Data set while the clock is low; read back at the rising edge
   task automatic bit_x(input logic b, output logic r);
      mosi_out = b;
      tick(2);
      sclk_out = 1'b1;
      r = miso_in;
      tick(2);
      sclk_out = 1'b0;
   endtask

   // One framed command of n bytes, then nrd bytes read back
   task automatic frame(input int n, input int nrd, output logic [7:0] rd);
      logic r;
      rd = 8'h00;
      cs_n_out = 1'b0;
      tick(2);
      for (int i = 0; i < n * 8; i++)
         bit_x(buf_q[i / 8][7 - i % 8], r);
      for (int i = 0; i < nrd * 8; i++) begin
         bit_x(~mosi_out, r);
         rd = {rd[6:0], r};
      end
      tick(2);
      cs_n_out = 1'b1;
      mosi_out = ~mosi_out;
      tick(3);
   endtask

   // A reset in mid-operation may corrupt data, so wait for quiet first
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy_in !== 1'b0 && k < 5000) begin
         tick(1);
         k++;
      end
   endtask
endmodule
`default_nettype wire

//--- tb/flash_lock_cmd_tb.sv
// Self-checking bench for the lock, reset and counter command decoder
`timescale 1ns/1ps
`default_nettype none
module flash_lock_cmd_tb
   import flash_lock_pkg::*;
;
   localparam int POLL = 4;
   logic clk_in, resetn_in, cs_n_in, sclk_in, serial_in, serial_out_q_out;
   logic serial_oe_out, write_enable_latch_in, lock_scheme_select_in;
   logic range_protected_in, prot_out, sw_reset_out, wel_clear_out;
   logic busy_out, counter_zero_out, rx_valid_out, hmac_start_out;
   logic hmac_done_in, hmac_match_in, sig_ok;
   logic [23:0] prot_addr_in;
   logic [7:0] ctr_status_out, rx_byte_out, hmac_type_out, ty;
   logic [3:0] counter_init_flag_out, hmac_key_valid_out;
   logic [1:0] counter_idx_out, zidx;
   logic [31:0] rnd;
   logic [15:0] lock_m;
   int seed, err_count, checked, sw_n, zero_n, rx_n;

   flash_lock_cmd #(.POLL_CYC(POLL)) i_flash_lock_cmd (.*);
   spi_host_model i_host (.clk_in(clk_in), .busy_in(busy_out),
      .miso_in(serial_out_q_out), .cs_n_out(cs_n_in), .sclk_out(sclk_in),
      .mosi_out(serial_in));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // Protection query inputs wander at random every cycle
   always @(posedge clk_in) begin
      #1;
      rnd = $random(seed);
      lock_scheme_select_in = rnd[0];
      range_protected_in = rnd[1];
      prot_addr_in = rnd[31:8];
   end

   // Signature engine stand-in: answers a little after the polling delay, or after twice it for a key update
   always begin
      @(posedge clk_in);
      #1;
      if (hmac_start_out === 1'b1) begin
         repeat ((hmac_type_out === CT_HMAC_KEY) ? 2 * POLL + 2 : POLL + 2)
            @(posedge clk_in);
         #1;
         hmac_done_in = 1'b1;
         hmac_match_in = sig_ok;
         while (busy_out === 1'b1) @(posedge clk_in);
         #1;
         hmac_done_in = 1'b0;
         hmac_match_in = ~sig_ok;
      end
   end

   // Pulse counters, read before the edge's own updates land
   always @(posedge clk_in) begin
      if (sw_reset_out === 1'b1) sw_n++;
      if (counter_zero_out === 1'b1) zero_n++;
      if (counter_zero_out === 1'b1) zidx = counter_idx_out;
      if (rx_valid_out === 1'b1) rx_n++;
   end

   function automatic logic exp_prot(input logic s, input logic r,
                                     input logic [23:0] a);
      return s ? lock_m[a[LOCK_IDX_LO +: LOCK_IDX_W]] : r;
   endfunction

   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask

   task automatic chk_prot();
      logic e;
      @(posedge clk_in);
      #2;
      e = exp_prot(lock_scheme_select_in, range_protected_in, prot_addr_in);
      @(posedge clk_in);
      #2;
      chk(prot_out === e, "protect flag");
   endtask

   task automatic op1(input logic [7:0] op);
      logic [7:0] rd;
      i_host.buf_q[0] = op;
      i_host.frame(1, 0, rd);
   endtask

   task automatic lock_rd(input logic [23:0] a);
      logic [7:0] rd;
      i_host.buf_q[0] = OP_READ_LOCK;
      {i_host.buf_q[1], i_host.buf_q[2], i_host.buf_q[3]} = a;
      i_host.frame(4, 1, rd);
      chk(rd === {7'h00, lock_m[a[23:20]]}, "lock byte");
   endtask

   // Counter frame: opcode, type, address, reserved, key bytes, signature
   task automatic ctr_cmd(input logic [7:0] t, input logic [7:0] ad,
      input logic [7:0] kb, input int len, input logic ok,
      input logic [7:0] ex);
      logic [7:0] rd;
      int n0;
      sig_ok = ok;
      i_host.buf_q[0] = OP_COUNTER;
      i_host.buf_q[1] = t;
      i_host.buf_q[2] = ad;
      i_host.buf_q[3] = 8'h00;
      for (int i = 4; i < 80; i++)
         i_host.buf_q[i] = (i < 36) ? kb : 8'($random(seed));
      n0 = rx_n;
      i_host.frame(len, 0, rd);
      // Every byte after the opcode goes to the signature engine
      chk(rx_n - n0 === len - 1
          && rx_byte_out === i_host.buf_q[len - 1], "rx bytes");
      i_host.tick(2);
      i_host.wait_idle();
      i_host.tick(3);
      chk(ctr_status_out === ex, "counter status");
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Watchdog sized well above the expected run
   initial begin
      repeat (90000) @(posedge clk_in);
      err_count++;
      end_sim();
   end

   initial begin
      seed = 32'h0fd69691;
      {resetn_in, write_enable_latch_in, hmac_done_in, hmac_match_in} = 4'h0;
      {lock_scheme_select_in, range_protected_in, sig_ok} = 3'h0;
      prot_addr_in = 24'h000000;
      lock_m = '1;
      repeat (8) @(posedge clk_in);
      #1 resetn_in = 1'b1;
      i_host.tick(2);
      repeat (3) lock_rd(24'($random(seed)));
      repeat (20) chk_prot();
      op1(OP_GLOBAL_UNLK);
      lock_rd(24'h5fffff);
      write_enable_latch_in = 1'b1;
      op1(OP_GLOBAL_UNLK);
      lock_m = '0;
      lock_rd(24'h000000);
      repeat (20) chk_prot();
      op1(OP_GLOBAL_LOCK);
      lock_m = '1;
      lock_rd(24'hf00001);
      op1(OP_GLOBAL_UNLK);
      lock_m = '0;
      op1(OP_RST_ENABLE);
      lock_rd(24'ha12345);
      op1(OP_RST_DEVICE);
      i_host.tick(3);
      chk(sw_n === 0 && busy_out === 1'b0, "reset not disarmed");
      i_host.wait_idle();
      op1(OP_RST_ENABLE);
      op1(OP_RST_DEVICE);
      i_host.tick(3);
      chk(sw_n === 1 && busy_out === 1'b1, "reset not taken");
      lock_m = '1;
      op1(OP_GLOBAL_UNLK);
      i_host.wait_idle();
      lock_rd(24'h7abcde);
      repeat (10) chk_prot();
      for (int i = 0; i < 3; i++) begin
         ty = (i == 0) ? CT_FIRST_RSVD : (i == 1) ? 8'hff : rnd[7:0] | 8'h04;
         ctr_cmd(ty, 8'h00, 8'h11, 41, 1'b1, ST_ERR_RSVD);
      end
      ctr_cmd(CT_ROOT_KEY, 8'h00, 8'h5a, 64, 1'b1, ST_ERR_PARAM);
      ctr_cmd(CT_ROOT_KEY, 8'h04, 8'h5a, 65, 1'b1, ST_ERR_PARAM);
      ctr_cmd(CT_HMAC_KEY, 8'h01, 8'h00, 41, 1'b1, ST_ERR_STATE);
      ctr_cmd(CT_ROOT_KEY, 8'h02, 8'h33, 65, 1'b0, ST_ERR_SIG);
      chk(zero_n === 0 && counter_init_flag_out === 4'h0, "exec");
      ctr_cmd(CT_ROOT_KEY, 8'h02, 8'hff, 65, 1'b1, ST_SUCCESS);
      chk(zero_n === 1 && zidx === 2'h2
          && counter_init_flag_out === 4'h4, "zero");
      ctr_cmd(CT_ROOT_KEY, 8'h02, 8'hff, 65, 1'b1, ST_SUCCESS);
      ctr_cmd(CT_ROOT_KEY, 8'h02, 8'h5a, 65, 1'b1, ST_SUCCESS);
      chk(zero_n === 1, "counter kept");
      ctr_cmd(CT_ROOT_KEY, 8'h02, 8'h77, 65, 1'b1, ST_ERR_STATE);
      // Key update is accepted once in this power cycle
      ctr_cmd(CT_HMAC_KEY, 8'h02, 8'h00, 41, 1'b1, ST_SUCCESS);
      chk(hmac_key_valid_out === 4'h4, "key valid");
      // Power cycle in mid-run: volatile keys drop, locks come back set
      resetn_in = 1'b0;
      i_host.tick(2);
      resetn_in = 1'b1;
      i_host.tick(2);
      chk(hmac_key_valid_out === 4'h0
          && counter_init_flag_out === 4'h0, "power cycle");
      lock_rd(24'h2468ac);
      end_sim();
   end
endmodule
`default_nettype wire
